//--- dv/lsl_driver_bench.sv
// Self-checking testbench for the LED shift-latch driver.
`timescale 1ns/1ns
module lsl_driver_bench;
   import lsl_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        out_disable = 1'b0;
   logic        shift_clk;
   logic        latch_clk;
   logic        serial_din;
   logic        cascade_out;
   logic [15:0] drive_out;
   logic [15:0] drive_out_oe;
   int          err_total = 0;
   int          samples_checked = 0;
   always #10 mclk = ~mclk;
   lsl_host i_host (.mclk(mclk), .shift_clk(shift_clk), .latch_clk(latch_clk),
      .serial_din(serial_din));
   lsl_driver i_dut (.mclk(mclk), .rst_n(rst_n), .shift_clk(shift_clk),
      .latch_clk(latch_clk), .serial_din(serial_din), .out_disable(out_disable),
      .cascade_out(cascade_out), .drive_out(drive_out), .drive_out_oe(drive_out_oe));
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic t_frame();
      i_host.send(16'ha5c3);
      i_host.latch();
      cmp("enable", 16'ha5c3, drive_out_oe);
      cmp("drive", LSL_DRIVE_HIGH, drive_out);
      cmp("cascade", 16'h0001, {15'h0, cascade_out});
   endtask
   task automatic t_hold();
      i_host.send(16'h3c0f);
      cmp("held", 16'ha5c3, drive_out_oe);
      cmp("cascade", 16'h0000, {15'h0, cascade_out});
   endtask
   task automatic t_disable();
      out_disable <= 1'b1;
      repeat (4) @(posedge mclk);
      cmp("disabled", 16'h0000, drive_out_oe);
      i_host.send(16'h8001);
      cmp("cascade", 16'h0001, {15'h0, cascade_out});
      i_host.latch();
      cmp("disabled", 16'h0000, drive_out_oe);
      out_disable <= 1'b0;
      repeat (4) @(posedge mclk);
      cmp("enable", 16'h8001, drive_out_oe);
   endtask
   task automatic t_clear();
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp("clear", 16'h0000, drive_out_oe);
      cmp("cascade", 16'h0000, {15'h0, cascade_out});
      rst_n <= 1'b1;
      i_host.latch();
      cmp("cleared", 16'h0000, drive_out_oe);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_frame();
      t_hold();
      t_disable();
      t_clear();
      give_verdict();
   end
   initial begin
      #60000;
      err_total++;
      give_verdict();
   end
endmodule

//--- dv/lsl_host.sv
// Host model driving serial frames onto the shift and latch pins.
`timescale 1ns/1ns
module lsl_host (
   // Clock.
   input  wire logic mclk,
   // Host pins.
   output logic      shift_clk,
   output logic      latch_clk,
   output logic      serial_din
);
   initial begin
      shift_clk = 1'b0;
      latch_clk = 1'b0;
      serial_din = 1'b0;
   end
   task automatic send(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         serial_din <= w[i];
         repeat (4) @(posedge mclk);
         shift_clk <= 1'b1;
         repeat (4) @(posedge mclk);
         shift_clk <= 1'b0;
      end
      serial_din <= ~w[0];
   endtask
   task automatic latch();
      repeat (4) @(posedge mclk);
      latch_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      latch_clk <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

//--- pkg/lsl_edge_if.sv
// Interface carrying the captured clock edges from the pin sampler to the core.
`timescale 1ns/1ns
interface lsl_edge_if;
   logic shift_rise;
   logic latch_rise;
   logic serial_in;
   modport src (output shift_rise, output latch_rise, output serial_in);
   modport dst (input shift_rise, input latch_rise, input serial_in);
endinterface

//--- pkg/lsl_pkg.sv
// Package with widths, reset values and the drive level of the LED shift-latch driver.
package lsl_pkg;
   localparam int          LSL_STAGES     = 16;
   localparam logic [15:0] LSL_SHIFT_RST  = 16'h0000;
   localparam logic [15:0] LSL_LATCH_RST  = 16'h0000;
   localparam logic [1:0]  LSL_SYNC_RST   = 2'h0;
   localparam logic [15:0] LSL_DRIVE_HIGH = 16'hffff;
   typedef logic [LSL_STAGES-1:0] lsl_word_t;
endpackage

//--- rtl/lsl_driver.sv
// Sixteen-stage serial shift register with holding latch driving LED outputs.
// Function
// - Sixteen shift stages each with latch stage.
// - Shift and latch on rising edges only.
// - Shift and latch clocks are independent.
// - Shift edge takes input, advances stages.
// - Latch edge copies all stages to outputs.
// - Cascade output follows last shift stage.
// - Clear low empties shift and latch asynchronously.
// - During clear outputs off, cascade low.
// - Disable high floats outputs, cascade stays.
// - Disable never stops shifting.
// - Latched one drives high, zero floats.
`timescale 1ns/1ns
module lsl_driver
   import lsl_pkg::*;
(
   // System clock and clear.
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Host serial link.
   input  wire logic        shift_clk,
   input  wire logic        latch_clk,
   input  wire logic        serial_din,
   input  wire logic        out_disable,
   // Cascade output.
   output logic             cascade_out,
   // LED drive outputs, driven high when enabled.
   output logic [15:0]      drive_out,
   output logic [15:0]      drive_out_oe
);
   lsl_edge_if edges ();

   lsl_word_t shift_reg;
   lsl_word_t latch_reg;
   lsl_word_t next_shift;
   logic [1:0] sync_dis;
   wire        dis_level;

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   lsl_pin_sync u_sync (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .shift_clk  (shift_clk),
      .latch_clk  (latch_clk),
      .serial_din (serial_din),
      .edges      (edges.src)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_dis <= LSL_SYNC_RST;
      end else begin
         sync_dis <= {sync_dis[0], out_disable};
      end
   end
   assign dis_level = sync_dis[1];

   // ---------------------------------------------------------------
   // Shift and latch stages
   // ---------------------------------------------------------------
   // Input enters stage zero.
   assign next_shift = {shift_reg[LSL_STAGES-2:0], edges.serial_in};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= LSL_SHIFT_RST;
      end else if (edges.shift_rise) begin
         shift_reg <= next_shift;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= LSL_LATCH_RST;
      end else if (edges.latch_rise) begin
         latch_reg <= shift_reg;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Cascade shows last stage.
   assign cascade_out = shift_reg[LSL_STAGES-1];
   assign drive_out   = LSL_DRIVE_HIGH;

   genvar gi;
   generate
      for (gi = 0; gi < LSL_STAGES; gi++) begin : g_out
         // Drive only a latched one; disable floats all.
         assign drive_out_oe[gi] = latch_reg[gi] & ~dis_level;
      end
   endgenerate

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking

   clear_outputs_a: assert property (@(posedge mclk) !rst_n |->
      (drive_out_oe == 16'h0000 && !cascade_out))
      else $error("Outputs not off during clear");
   shift_step_a: assert property (disable iff (!rst_n) edges.shift_rise |=>
      shift_reg == {$past(shift_reg[14:0]), $past(edges.serial_in)})
      else $error("Shift step wrong");
   shift_hold_a: assert property (disable iff (!rst_n) !edges.shift_rise |=>
      $stable(shift_reg))
      else $error("Shift register moved without edge");
   latch_copy_a: assert property (disable iff (!rst_n) edges.latch_rise |=>
      latch_reg == $past(shift_reg))
      else $error("Latch did not copy");
   latch_hold_a: assert property (disable iff (!rst_n) !edges.latch_rise |=>
      $stable(latch_reg))
      else $error("Latch moved without edge");
   cascade_last_a: assert property (disable iff (!rst_n)
      cascade_out == shift_reg[15])
      else $error("Cascade not last stage");
   disable_float_a: assert property (disable iff (!rst_n) dis_level |->
      drive_out_oe == 16'h0000)
      else $error("Outputs driven while disabled");
   lit_drive_a: assert property (disable iff (!rst_n) !dis_level |->
      drive_out_oe == latch_reg)
      else $error("Drive enable not latched value");
   disable_shift_a: assert property (disable iff (!rst_n)
      (dis_level && edges.shift_rise) |=> shift_reg[0] == $past(edges.serial_in))
      else $error("Shift stalled while disabled");

   shift_seen_c: cover property (disable iff (!rst_n) edges.shift_rise);
   latch_seen_c: cover property (disable iff (!rst_n) edges.latch_rise && shift_reg != 16'h0000);
   disabled_c: cover property (disable iff (!rst_n) dis_level && latch_reg != 16'h0000);
endmodule

//--- rtl/lsl_pin_sync.sv
// Pin sampler: two-stage synchronisers and rising-edge detection for the host pins.
`timescale 1ns/1ns
module lsl_pin_sync
   import lsl_pkg::*;
(
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic rst_n,
   // Raw host pins.
   input  wire logic shift_clk,
   input  wire logic latch_clk,
   input  wire logic serial_din,
   // Captured events.
   lsl_edge_if.src   edges
);
   logic [1:0] sync_shift;
   logic [1:0] sync_latch;
   logic [1:0] sync_data;
   logic       prev_shift;
   logic       prev_latch;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_shift <= LSL_SYNC_RST;
         sync_latch <= LSL_SYNC_RST;
         sync_data  <= LSL_SYNC_RST;
         prev_shift <= 1'b0;
         prev_latch <= 1'b0;
      end else begin
         sync_shift <= {sync_shift[0], shift_clk};
         sync_latch <= {sync_latch[0], latch_clk};
         sync_data  <= {sync_data[0], serial_din};
         prev_shift <= sync_shift[1];
         prev_latch <= sync_latch[1];
      end
   end

   assign edges.shift_rise = sync_shift[1] & ~prev_shift;
   assign edges.latch_rise = sync_latch[1] & ~prev_latch;
   assign edges.serial_in  = sync_data[1];
endmodule
